// >>> hw/dasr_clk_gen.sv
// Port clock enable generator: phase accumulator giving 16, 8 or 4 MHz ticks from the system clock.
// Assumes a 100 MHz clock; ticks are one-cycle enables, not a clock.
`timescale 1ns/100ps
`include "dasr_defs.svh"

module dasr_clk_gen (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_n,
  // Rate select
  input  wire logic [1:0] clk_sel,
  // Port clock enable
  output logic            tick
);
  import dasr_pkg::*;

  logic [6:0] acc_q;
  logic [6:0] acc_d;
  logic       tick_d;
  logic [6:0] inc;
  logic [7:0] sum;

  // ==========================================================
  // Rate step and accumulator wrap
  always_comb begin
    case (clk_sel)
      `DASR_CLKSEL_16MHZ: inc = `DASR_PORT_16_MHZ;   // [R9]
      `DASR_CLKSEL_8MHZ:  inc = `DASR_PORT_8_MHZ;    // [R9]
      default:            inc = `DASR_PORT_4_MHZ;    // [R9]
    endcase
    sum = {1'b0, acc_q} + {1'b0, inc};
    if (sum >= {1'b0, `DASR_SYS_CLK_MHZ}) begin
      acc_d  = 7'(sum - {1'b0, `DASR_SYS_CLK_MHZ});
      tick_d = 1'b1;
    end else begin
      acc_d  = sum[6:0];
      tick_d = 1'b0;
    end
  end

  // Registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= 7'h00;
      tick  <= 1'b0;
    end else begin
      acc_q <= acc_d;
      tick  <= tick_d;
    end
  end

endmodule : dasr_clk_gen

// >>> hw/dasr_defs.svh
// Offsets, field positions, reset values and timing figures of the debug access system registers.
// Assumes inclusion by bare name from every file that needs the figures.
`ifndef DASR_DEFS_SVH
`define DASR_DEFS_SVH

// ==========================================================
// Register offsets on the link-side register port
`define DASR_OFS_KEY_STATE    4'h7
`define DASR_OFS_RESET_REQ    4'h8
`define DASR_OFS_CLK_CTRL     4'h9
`define DASR_OFS_SYS_CTRL     4'hA
`define DASR_OFS_SYS_FLAGS    4'hB
`define DASR_OFS_CRC_STATE    4'hC

// ==========================================================
// Field positions
`define DASR_BIT_UROW_KEY     5
`define DASR_BIT_NVM_KEY      4
`define DASR_BIT_ERASE_KEY    3
`define DASR_BIT_UROW_DONE    1
`define DASR_BIT_CLK_REQ      0
`define DASR_BIT_RST_ACTIVE   5
`define DASR_BIT_ASLEEP       4
`define DASR_BIT_NVM_READY    3
`define DASR_BIT_UROW_READY   2
`define DASR_BIT_LOCKED       0

// ==========================================================
// Values and reset values
`define DASR_RESET_SIGNATURE  8'h59
`define DASR_CLKSEL_RESERVED  2'h0
`define DASR_CLKSEL_16MHZ     2'h1
`define DASR_CLKSEL_8MHZ      2'h2
`define DASR_CLKSEL_4MHZ      2'h3
`define DASR_RST_CLKSEL       2'h3
`define DASR_RST_LOCKED       1'b1

// ==========================================================
// Port clock rates in MHz against the system clock rate in MHz
`define DASR_SYS_CLK_MHZ      7'd100
`define DASR_PORT_16_MHZ      7'd16
`define DASR_PORT_8_MHZ       7'd8
`define DASR_PORT_4_MHZ       7'd4

`endif

// >>> hw/dasr_pkg.sv
// Types shared by the debug access system register block.
// Assumes the constants header is included where figures are needed.
package dasr_pkg;

  // ==========================================================
  // Register access from the link instruction layer
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dasr_req_t;

  // ==========================================================
  // Key decoder and NVM controller events, one-cycle pulses
  typedef struct packed {
    logic urow_key_ok;
    logic nvm_key_ok;
    logic erase_key_ok;
    logic nvm_prog_done;
    logic chip_erase_done;
  } dasr_evt_t;

  // ==========================================================
  // Levels reported by the system domain
  typedef struct packed {
    logic       in_reset;
    logic       asleep;
    logic       nvm_ready;
    logic       urow_ready;
    logic       locked;
    logic [2:0] crc_state;
  } dasr_sys_t;

endpackage : dasr_pkg

// >>> hw/dasr_regs.sv
// Access-layer register set of the single-wire debug port: keys, system reset, clocks, status.
// Assumes requests come only from the link instruction layer; events are one-cycle pulses.
//
// Notes on behaviour
// R1: Port disable clears keys, clock request, configuration.
// R2: Key status shows row, program, erase keys.
// R3: Program key clears when programming finishes.
// R4: Erase key clears when chip erase completes.
// R5: Signature write holds system reset asserted.
// R6: Any other value releases held reset.
// R7: Reset request reads bit0 hold, rest zero.
// R8: System reset never resets this port.
// R9: Clock select picks 16, 8, 4 MHz.
// R10: Port clock defaults to 4 MHz.
// R11: Row-done write starts user row programming.
// R12: Programmer writes row-done after data in RAM.
// R13: Row-done write ignored without row key.
// R14: Clock request bit drives system clock request.
// R15: Clock request set on enable, cleared disable.
// R16: Reset-active flag sticky, cleared by read.
// R17: Asleep flag follows system sleep state.
// R18: Program-ready flag shows programming may start.
// R19: Row-ready flag shows row programming may start.
// R20: Lock flag resets one, follows lock bits.
// R21: Checksum field shows one-hot state code.
// R22: Registers reachable only from link port.
`timescale 1ns/100ps
`include "dasr_defs.svh"

module dasr_regs (
  // Clock and port reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Link register access
  input  wire dasr_pkg::dasr_req_t req,
  output logic [7:0]             rdata,
  output logic                   rvalid,
  // Port enable and disable pulses from the physical layer
  input  wire logic              port_enable,
  input  wire logic              port_disable,
  // Key and NVM events
  input  wire dasr_pkg::dasr_evt_t evt,
  // System domain levels
  input  wire dasr_pkg::dasr_sys_t sys,
  // Physical layer control
  output logic                   phy_off,
  output logic                   port_reset,
  output logic                   port_clk_en,
  // System domain control
  output logic                   sys_reset_hold,
  output logic                   sys_clk_request,
  output logic                   urow_done
);
  import dasr_pkg::*;

  // ==========================================================
  // State
  logic [2:0] keys_q, keys_d;         // {row, program, erase}
  logic       hold_q, hold_d;
  logic [1:0] sel_q, sel_d;
  logic       creq_q, creq_d;
  logic       rsta_q, rsta_d;
  dasr_sys_t  sys_q, sys_d;
  logic       off_q, off_d;
  logic       prst_d;
  logic       udone_d;
  logic [7:0] rdata_d;
  logic       tick;
  logic       clk_en_d;

  logic wr_key, wr_rst, wr_clk, wr_ctl, rd_rst, rd_flg;

  // Decoded accesses; no other port reaches these registers [R22]
  assign wr_key = req.wr && (req.addr == `DASR_OFS_KEY_STATE);
  assign wr_rst = req.wr && (req.addr == `DASR_OFS_RESET_REQ);
  assign wr_clk = req.wr && (req.addr == `DASR_OFS_CLK_CTRL);
  assign wr_ctl = req.wr && (req.addr == `DASR_OFS_SYS_CTRL);
  assign rd_rst = req.rd && (req.addr == `DASR_OFS_RESET_REQ);
  assign rd_flg = req.rd && (req.addr == `DASR_OFS_SYS_FLAGS);

  // ==========================================================
  // Keys, reset hold, clock select, clock request
  always_comb begin
    keys_d  = keys_q;
    hold_d  = hold_q;
    sel_d   = sel_q;
    creq_d  = creq_q;
    off_d   = off_q;
    prst_d  = 1'b0;
    udone_d = wr_ctl && req.wdata[`DASR_BIT_UROW_DONE] && keys_q[2];   // [R11] [R13]
    // Software may drop the row key; decoder sets win
    if (wr_key && !req.wdata[`DASR_BIT_UROW_KEY])
      keys_d[2] = 1'b0;
    if (evt.nvm_prog_done)
      keys_d[1] = 1'b0;                                                // [R3]
    if (evt.chip_erase_done)
      keys_d[0] = 1'b0;                                                // [R4]
    if (evt.urow_key_ok)
      keys_d[2] = 1'b1;                                                // [R2]
    if (evt.nvm_key_ok)
      keys_d[1] = 1'b1;                                                // [R2]
    if (evt.erase_key_ok)
      keys_d[0] = 1'b1;                                                // [R2]
    if (wr_rst)
      hold_d = (req.wdata == `DASR_RESET_SIGNATURE);                   // [R5] [R6]
    if (wr_clk && (req.wdata[1:0] != `DASR_CLKSEL_RESERVED))
      sel_d = req.wdata[1:0];                                          // [R9]
    if (wr_ctl)
      creq_d = req.wdata[`DASR_BIT_CLK_REQ];                           // [R14]
    if (port_enable) begin
      creq_d = 1'b1;                                                   // [R15]
      sel_d  = `DASR_RST_CLKSEL;                                       // [R10]
      off_d  = 1'b0;
    end
    if (port_disable) begin
      keys_d  = 3'h0;                                                  // [R1]
      hold_d  = 1'b0;                                                  // [R1]
      sel_d   = `DASR_RST_CLKSEL;                                      // [R1] [R10]
      creq_d  = 1'b0;                                                  // [R1] [R15]
      off_d   = 1'b1;                                                  // [R1]
      prst_d  = 1'b1;                                                  // [R1]
      udone_d = 1'b0;
    end
  end

  // ==========================================================
  // System status capture; reset-active is sticky, set wins over read-clear
  always_comb begin
    sys_d  = sys;                                                      // [R17] [R18] [R19] [R20] [R21]
    rsta_d = (rsta_q && !rd_flg) || sys.in_reset || hold_q;            // [R16]
  end

  // ==========================================================
  // Read data, answered one cycle after the request
  always_comb begin
    rdata_d = 8'h00;
    case (req.addr)
      `DASR_OFS_KEY_STATE: rdata_d = {2'b00, keys_q, 3'b000};          // [R2]
      `DASR_OFS_RESET_REQ: rdata_d = {7'h00, hold_q};                  // [R7]
      `DASR_OFS_CLK_CTRL:  rdata_d = {6'h00, sel_q};
      `DASR_OFS_SYS_CTRL:  rdata_d = {7'h00, creq_q};
      `DASR_OFS_SYS_FLAGS: rdata_d = {2'b00, rsta_q, sys_q.asleep, sys_q.nvm_ready,
                                      sys_q.urow_ready, 1'b0, sys_q.locked};
      `DASR_OFS_CRC_STATE: rdata_d = {5'h00, sys_q.crc_state};         // [R21]
      default:             rdata_d = 8'h00;
    endcase
  end

  // Registers; only the port reset clears them, never the system reset [R8]
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      keys_q     <= 3'h0;
      hold_q     <= 1'b0;
      sel_q      <= `DASR_RST_CLKSEL;                                  // [R10]
      creq_q     <= 1'b0;
      off_q      <= 1'b0;
      rsta_q     <= 1'b0;
      sys_q      <= '{default: 1'b0, locked: `DASR_RST_LOCKED};        // [R20]
      port_reset <= 1'b0;
      urow_done  <= 1'b0;
      rdata      <= 8'h00;
      rvalid     <= 1'b0;
      port_clk_en <= 1'b0;
    end else begin
      keys_q     <= keys_d;
      hold_q     <= hold_d;
      sel_q      <= sel_d;
      creq_q     <= creq_d;
      off_q      <= off_d;
      rsta_q     <= rsta_d;
      sys_q      <= sys_d;
      port_reset <= prst_d;
      urow_done  <= udone_d;
      rdata      <= req.rd ? rdata_d : 8'h00;
      rvalid     <= req.rd;
      port_clk_en <= clk_en_d;
    end
  end

  assign sys_reset_hold  = hold_q;
  assign sys_clk_request = creq_q;
  assign phy_off         = off_q;

  // Port clock enable from the selected rate
  dasr_clk_gen u_clk_gen (
    .clk     (clk),
    .rst_n   (rst_n),
    .clk_sel (sel_q),
    .tick    (tick)
  );
  // Gated tick, registered so the output comes from a flop
  assign clk_en_d = tick && !off_q;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_sig_write;
    wr_rst && (req.wdata == `DASR_RESET_SIGNATURE) && !port_disable;
  endsequence
  sequence s_other_write;
    wr_rst && (req.wdata != `DASR_RESET_SIGNATURE);
  endsequence

  reset_hold_a: assert property (s_sig_write |=> sys_reset_hold ##1 rsta_q) // [R5]
    else $error("signature write did not hold system reset");
  reset_release_a: assert property (s_other_write |=> !sys_reset_hold) // [R6]
    else $error("other write did not release system reset");
  reset_readback_a: assert property (rd_rst |=> rvalid && rdata == {7'h00, $past(hold_q)}) // [R7]
    else $error("reset request readback wrong");
  disable_clear_a: assert property (port_disable |=> keys_q == 3'h0 && !sys_clk_request
                                    && sel_q == `DASR_RST_CLKSEL && port_reset && phy_off) // [R1]
    else $error("port disable left state behind");
  nvm_key_clear_a: assert property (evt.nvm_prog_done && !evt.nvm_key_ok |=> !keys_q[1]) // [R3]
    else $error("program key not cleared after programming");
  erase_key_clear_a: assert property (evt.chip_erase_done && !evt.erase_key_ok |=> !keys_q[0]) // [R4]
    else $error("erase key not cleared after chip erase");
  urow_gate_a: assert property (wr_ctl && !keys_q[2] |=> !urow_done) // [R13]
    else $error("row done accepted without row key");
  clk_req_write_a: assert property (wr_ctl && !port_enable && !port_disable
                                    |=> sys_clk_request == $past(req.wdata[0])) // [R14]
    else $error("clock request bit not taken");
  enable_default_a: assert property (port_enable && !port_disable |=> sys_clk_request
                                     && sel_q == `DASR_CLKSEL_4MHZ) // [R15]
    else $error("enable did not restore defaults");
  rst_sticky_a: assert property (sys.in_reset ##1 !sys.in_reset && !rd_flg && !hold_q
                                 |=> rsta_q) // [R16]
    else $error("reset-active flag not sticky");

  // ==========================================================
  // Checks on keys, clock select, row done and status reads

  // A level seen by the system domain, then a status read one cycle later
  sequence s_asleep_seen;
    sys.asleep ##1 rd_flg;
  endsequence
  sequence s_awake_seen;
    !sys.asleep ##1 rd_flg;
  endsequence
  sequence s_nvm_ready_seen;
    sys.nvm_ready ##1 rd_flg;
  endsequence
  sequence s_urow_ready_seen;
    sys.urow_ready ##1 rd_flg;
  endsequence
  sequence s_locked_seen;
    sys.locked ##1 rd_flg;
  endsequence
  sequence s_unlocked_seen;
    !sys.locked ##1 rd_flg;
  endsequence

  // Keys
  key_row_set_a: assert property (evt.urow_key_ok && !port_disable |=> keys_q[2]) // [R2]
    else $error("row key not reported");
  key_nvm_set_a: assert property (evt.nvm_key_ok && !port_disable |=> keys_q[1]) // [R2]
    else $error("program key not reported");
  key_erase_set_a: assert property (evt.erase_key_ok && !port_disable |=> keys_q[0]) // [R2]
    else $error("erase key not reported");
  key_readback_a: assert property (req.rd && req.addr == `DASR_OFS_KEY_STATE
                                   |=> rdata == {2'b00, $past(keys_q), 3'b000}) // [R2]
    else $error("key state readback wrong");

  // Clock select and port clock
  clk_sel_take_a: assert property (wr_clk && req.wdata[1:0] != `DASR_CLKSEL_RESERVED
                                   && !port_enable && !port_disable
                                   |=> sel_q == $past(req.wdata[1:0])) // [R9]
    else $error("clock select write not taken");
  clk_sel_keep_a: assert property (wr_clk && req.wdata[1:0] == `DASR_CLKSEL_RESERVED
                                   && !port_enable && !port_disable |=> $stable(sel_q)) // [R9]
    else $error("reserved clock code was taken");
  clk_sel_read_a: assert property (req.rd && req.addr == `DASR_OFS_CLK_CTRL
                                   |=> rdata == {6'h00, $past(sel_q)}) // [R9]
    else $error("clock select readback wrong");
  tick_gap_a: assert property (port_clk_en |=> (!port_clk_en) [*5]) // [R9]
    else $error("port clock ticks closer than the fastest rate");
  port_kept_a: assert property (sys.in_reset && !wr_clk && !wr_ctl && !port_enable && !port_disable
                                |=> $stable(sel_q) && $stable(sys_clk_request)) // [R8]
    else $error("system reset disturbed port state");

  // Row done
  urow_start_a: assert property (wr_ctl && req.wdata[`DASR_BIT_UROW_DONE] && keys_q[2] && !port_disable
                                 |=> urow_done) // [R11]
    else $error("row done with key did not start programming");

  // Status reads
  rsta_set_a: assert property (sys.in_reset || sys_reset_hold |=> rsta_q) // [R16]
    else $error("reset-active flag not set");
  rsta_clear_a: assert property (rd_flg && !sys.in_reset && !sys_reset_hold |=> !rsta_q) // [R16]
    else $error("reset-active flag not cleared by read");
  rsta_read_a: assert property (rd_flg |=> rdata[`DASR_BIT_RST_ACTIVE] == $past(rsta_q)) // [R16]
    else $error("reset-active flag read wrong");
  asleep_read_a: assert property (s_asleep_seen |=> rdata[`DASR_BIT_ASLEEP]) // [R17]
    else $error("sleep flag not shown");
  awake_read_a: assert property (s_awake_seen |=> !rdata[`DASR_BIT_ASLEEP]) // [R17]
    else $error("sleep flag shown while awake");
  nvm_ready_read_a: assert property (s_nvm_ready_seen |=> rdata[`DASR_BIT_NVM_READY]) // [R18]
    else $error("program-ready flag not shown");
  urow_ready_read_a: assert property (s_urow_ready_seen |=> rdata[`DASR_BIT_UROW_READY]) // [R19]
    else $error("row-ready flag not shown");
  lock_read_a: assert property (s_locked_seen |=> rdata[`DASR_BIT_LOCKED]) // [R20]
    else $error("lock flag not shown");
  unlock_read_a: assert property (s_unlocked_seen |=> !rdata[`DASR_BIT_LOCKED]) // [R20]
    else $error("lock flag shown while unlocked");
  crc_read_a: assert property (req.rd && req.addr == `DASR_OFS_CRC_STATE
                               |=> rdata == {5'h00, $past(sys.crc_state, 2)}) // [R21]
    else $error("checksum state read wrong");

endmodule : dasr_regs

// >>> testbench/dasr_prog_model.sv
// Programmer model: issues register reads and writes on the link register port.
// Assumes one request at a time, driven at the falling clock edge.
`timescale 1ns/100ps

module dasr_prog_model (
  // Clock
  input  wire logic          clk,
  // Register port
  output dasr_pkg::dasr_req_t req,
  input  wire logic [7:0]    rdata,
  input  wire logic          rvalid
);
  import dasr_pkg::*;

  // ==========================================================
  // Requests reach the registers only through this port
  initial req = '0;

  // One write strobe held across one rising edge
  task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d}; // Stale lines do not keep old value
  endtask : write_reg

  // One read strobe, answer awaited for a bounded count
  task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
    int n;
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    d = (rvalid === 1'b1) ? rdata : 8'hXX;
  endtask : read_reg
endmodule : dasr_prog_model

// >>> testbench/debug_access_system_regs_bench.sv
// Self-checking bench of the debug access system registers.
// Assumes the programmer model on the register port; events and levels driven here.
`timescale 1ns/100ps
`include "dasr_defs.svh"

module debug_access_system_regs_bench;
  import dasr_pkg::*;
  logic       clk = 1'b0, rst_n = 1'b0, port_enable = 1'b0, port_disable = 1'b0;
  dasr_req_t  req;
  dasr_evt_t  evt = '0;
  dasr_sys_t  sys = 8'h08;
  logic [7:0] rdata, d, v;
  logic       rvalid, phy_off, port_reset, port_clk_en, sys_reset_hold, sys_clk_request, urow_done;
  int         fail_count = 0, checks_done = 0, cycles = 0, nu, nr, nt;

  // ==========================================================
  // Clock, design and programmer
  always #5 clk = ~clk;
  dasr_regs i_dasr_regs (.clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rvalid(rvalid),
    .port_enable(port_enable), .port_disable(port_disable), .evt(evt), .sys(sys), .phy_off(phy_off),
    .port_reset(port_reset), .port_clk_en(port_clk_en), .sys_reset_hold(sys_reset_hold),
    .sys_clk_request(sys_clk_request), .urow_done(urow_done));
  dasr_prog_model i_dasr_prog_model (.clk(clk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // Status byte expected from levels and the reset-active flag
  function automatic logic [7:0] flags_exp(input dasr_sys_t s, input logic rsta);
    return {2'b00, rsta, s.asleep, s.nvm_ready, s.urow_ready, 1'b0, s.locked};
  endfunction : flags_exp

  // ==========================================================
  // Compare, report, close
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp, input string name);
    logic [7:0] r;
    i_dasr_prog_model.read_reg(a, r);
    check(name, r, exp);
  endtask : rchk

  task automatic wr(input logic [3:0] a, input logic [7:0] dt);
    i_dasr_prog_model.write_reg(a, dt);
  endtask : wr

  // Pulse counts of row-done and port reset over three cycles
  task automatic watch;
    nu = 0;
    nr = 0;
    repeat (3) begin
      nu += urow_done;
      nr += port_reset;
      @(negedge clk);
    end
  endtask : watch

  task automatic pulse(input dasr_evt_t e, input logic en, input logic dis);
    @(negedge clk);
    {evt, port_enable, port_disable} = {e, en, dis};
    @(negedge clk);
    {evt, port_enable, port_disable} = '0;
  endtask : pulse

  // Port clock ticks over 100 cycles
  task automatic ticks;
    nt = 0;
    repeat (100) begin
      @(negedge clk);
      nt += port_clk_en;
    end
  endtask : ticks

  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      close_out();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(31285));
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rchk(`DASR_OFS_KEY_STATE, 8'h00, "key_rst");
    rchk(`DASR_OFS_RESET_REQ, 8'h00, "rreq_rst");
    rchk(`DASR_OFS_CLK_CTRL, 8'h03, "sel_rst");
    rchk(`DASR_OFS_SYS_FLAGS, 8'h01, "flags_rst");
    rchk(`DASR_OFS_CRC_STATE, 8'h00, "crc_rst");
    rchk(4'hF, 8'h00, "unmapped");
    pulse('0, 1'b1, 1'b0);
    rchk(`DASR_OFS_SYS_CTRL, 8'h01, "system_clock_request_en");
    // Every clock code, then the reserved code
    for (int s = 1; s < 4; s++) begin
      wr(`DASR_OFS_CLK_CTRL, 8'(s));
      rchk(`DASR_OFS_CLK_CTRL, 8'(s), "sel_rb");
      ticks();
      check("ticks", 8'(nt), (s == 1) ? 8'h10 : (s == 2) ? 8'h08 : 8'h04);
    end
    wr(`DASR_OFS_CLK_CTRL, 8'h01);
    wr(`DASR_OFS_CLK_CTRL, 8'h00);
    rchk(`DASR_OFS_CLK_CTRL, 8'h01, "sel_rsvd");
    // System reset hold and release
    wr(`DASR_OFS_RESET_REQ, `DASR_RESET_SIGNATURE);
    check("hold", {7'h0, sys_reset_hold}, 8'h01);
    rchk(`DASR_OFS_RESET_REQ, 8'h01, "rreq_hold");
    rchk(`DASR_OFS_SYS_FLAGS, 8'h21, "rsta_hold");
    rchk(`DASR_OFS_CLK_CTRL, 8'h01, "sel_kept");
    v = $urandom;
    if (v == `DASR_RESET_SIGNATURE) v = 8'h00;
    wr(`DASR_OFS_RESET_REQ, v);
    check("release", {7'h0, sys_reset_hold}, 8'h00);
    rchk(`DASR_OFS_RESET_REQ, 8'h00, "rreq_rel");
    rchk(`DASR_OFS_SYS_FLAGS, 8'h21, "rsta_sticky");
    rchk(`DASR_OFS_SYS_FLAGS, 8'h01, "rsta_rdclr");
    // Keys set and cleared by their sequences
    pulse('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0}, 1'b0, 1'b0);
    rchk(`DASR_OFS_KEY_STATE, 8'h38, "keys");
    pulse('{1'b0, 1'b0, 1'b0, 1'b1, 1'b0}, 1'b0, 1'b0);
    rchk(`DASR_OFS_KEY_STATE, 8'h28, "nvm_done");
    pulse('{1'b0, 1'b0, 1'b0, 1'b0, 1'b1}, 1'b0, 1'b0);
    rchk(`DASR_OFS_KEY_STATE, 8'h20, "erase_done");
    // Row done refused without the row key, taken with it
    wr(`DASR_OFS_KEY_STATE, 8'h00);
    wr(`DASR_OFS_SYS_CTRL, 8'h03);
    watch();
    check("row_nokey", 8'(nu), 8'h00);
    pulse('{1'b1, 1'b0, 1'b0, 1'b0, 1'b0}, 1'b0, 1'b0);
    wr(`DASR_OFS_SYS_CTRL, 8'h03);
    watch();
    check("row_done", 8'(nu), 8'h01);
    wr(`DASR_OFS_SYS_CTRL, 8'h00);
    check("clkreq0", {7'h0, sys_clk_request}, 8'h00);
    wr(`DASR_OFS_SYS_CTRL, 8'h01);
    check("clkreq1", {7'h0, sys_clk_request}, 8'h01);
    // Random system levels and checksum codes
    repeat (24) begin
      v = $urandom;
      sys = {1'b0, v[5:2], (v[1:0] == 2'h0) ? 3'h0 : 3'(3'h1 << (v[1:0] - 2'h1))};
      wr(`DASR_OFS_SYS_FLAGS, ~v);
      rchk(`DASR_OFS_SYS_FLAGS, flags_exp(sys, 1'b0), "flags");
      rchk(`DASR_OFS_CRC_STATE, {5'h0, sys.crc_state}, "crc");
    end
    sys.in_reset = 1'b1;
    rchk(`DASR_OFS_SYS_FLAGS, flags_exp(sys, 1'b1), "rsta_sys");
    sys.in_reset = 1'b0;
    i_dasr_prog_model.read_reg(`DASR_OFS_SYS_FLAGS, d);
    check("rsta_keep", d, flags_exp(sys, 1'b1));
    rchk(`DASR_OFS_SYS_FLAGS, flags_exp(sys, 1'b0), "rsta_clr");
    // Disable drops everything, enable restores defaults
    wr(`DASR_OFS_RESET_REQ, `DASR_RESET_SIGNATURE);
    pulse('0, 1'b0, 1'b1);
    watch();
    check("port_rst", 8'(nr), 8'h01);
    check("dis_out", {phy_off, sys_clk_request, sys_reset_hold}, 8'h04);
    rchk(`DASR_OFS_KEY_STATE, 8'h00, "dis_keys");
    ticks();
    check("dis_ticks", 8'(nt), 8'h00);
    pulse('0, 1'b1, 1'b0);
    rchk(`DASR_OFS_CLK_CTRL, 8'h03, "sel_en");
    check("en_out", {phy_off, sys_clk_request}, 8'h01);
    close_out();
  end
endmodule : debug_access_system_regs_bench
